/* cslr_pkg.sv */
// constants, types and decode table for the stack, logic and rotate executor
//
// How it works
// - idle opcode 9D: one byte, one cycle, only the program counter advances
// - opcode 62 swaps accumulator nibbles in one cycle, flags untouched
// - or-with-memory puts accumulator OR operand back into the accumulator
// - after the OR: overflow cleared, negative from bit 7, zero on zero result
// - OR opcodes AA BA CA DA EA FA 9EDA 9EEA take 2 3 4 4 3 3 5 4 cycles
// - accumulator push: store at stack pointer, then decrement; two cycles, flags kept
// - index high push: store at stack pointer, then decrement; two cycles, flags kept
// - index low push: store at stack pointer, then decrement; two cycles, flags kept
// - accumulator pop: increment stack pointer, then load from it; three cycles
// - index high pop: increment stack pointer, then load from it; three cycles
// - index low pop: increment stack pointer, then load from it; three cycles
// - rotate left: bit 0 takes old carry, carry takes old bit 7
// - rotate flags: carry old bit 7, negative bit 7, zero, overflow negative xor carry
// - rotate opcodes 39 49 59 69 79 9E69 take 5 1 1 5 4 6 cycles
// - carry chaining lets successive rotates move a multi-byte value left
`default_nettype none
package cslr_pkg;
  // ----------------------------------------
  // opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_IDLE    = 8'h9d;
  localparam logic [7:0] OP_NSWAP   = 8'h62;
  localparam logic [7:0] OP_PAGE2   = 8'h9e;
  localparam logic [7:0] OP_OR_IMM  = 8'haa;
  localparam logic [7:0] OP_OR_DIR  = 8'hba;
  localparam logic [7:0] OP_OR_EXT  = 8'hca;
  localparam logic [7:0] OP_OR_IX2  = 8'hda;
  localparam logic [7:0] OP_OR_IX1  = 8'hea;
  localparam logic [7:0] OP_OR_IX   = 8'hfa;
  localparam logic [7:0] OP_PSH_A   = 8'h87;
  localparam logic [7:0] OP_PSH_H   = 8'h8b;
  localparam logic [7:0] OP_PSH_X   = 8'h89;
  localparam logic [7:0] OP_POP_A   = 8'h86;
  localparam logic [7:0] OP_POP_H   = 8'h8a;
  localparam logic [7:0] OP_POP_X   = 8'h88;
  localparam logic [7:0] OP_ROL_DIR = 8'h39;
  localparam logic [7:0] OP_ROL_A   = 8'h49;
  localparam logic [7:0] OP_ROL_X   = 8'h59;
  localparam logic [7:0] OP_ROL_IX1 = 8'h69;
  localparam logic [7:0] OP_ROL_IX  = 8'h79;
  // ----------------------------------------
  // cycle counts
  // ----------------------------------------
  localparam logic [2:0] CYC_ONE     = 3'h1;
  localparam logic [2:0] CYC_OR_IMM  = 3'h2;
  localparam logic [2:0] CYC_OR_DIR  = 3'h3;
  localparam logic [2:0] CYC_OR_EXT  = 3'h4;
  localparam logic [2:0] CYC_OR_IX2  = 3'h4;
  localparam logic [2:0] CYC_OR_IX1  = 3'h3;
  localparam logic [2:0] CYC_OR_IX   = 3'h3;
  localparam logic [2:0] CYC_OR_SP2  = 3'h5;
  localparam logic [2:0] CYC_OR_SP1  = 3'h4;
  localparam logic [2:0] CYC_PUSH    = 3'h2;
  localparam logic [2:0] CYC_POP     = 3'h3;
  localparam logic [2:0] CYC_ROL_DIR = 3'h5;
  localparam logic [2:0] CYC_ROL_IX1 = 3'h5;
  localparam logic [2:0] CYC_ROL_IX  = 3'h4;
  localparam logic [2:0] CYC_ROL_SP1 = 3'h6;
  // ----------------------------------------
  // flags layout and reset values
  // ----------------------------------------
  localparam int          FLG_C   = 0;
  localparam int          FLG_Z   = 1;
  localparam int          FLG_N   = 2;
  localparam int          FLG_I   = 3;
  localparam int          FLG_H   = 4;
  localparam int          FLG_V   = 7;
  localparam logic [7:0]  FLG_RST = 8'h68;
  localparam logic [15:0] SP_RST  = 16'h00ff;
  localparam logic [15:0] STK_STEP = 16'h0001;
  localparam logic [15:0] PC_STEP  = 16'h0001;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {CL_IDLE, CL_NSWAP, CL_OR, CL_PUSH, CL_POP, CL_ROL} cslr_cls_t;
  typedef enum logic [3:0] {
    M_INH, M_IMM, M_DIR, M_EXT, M_IX2, M_IX1, M_IX, M_SP2, M_SP1
  } cslr_mode_t;
  typedef enum logic [1:0] {R_ACC, R_IH, R_IL} cslr_sel_t;
  typedef enum logic [2:0] {
    S_FETCH = 3'b000,
    S_PAGE2 = 3'b001,
    S_OPND1 = 3'b011,
    S_OPND2 = 3'b010,
    S_READ  = 3'b110,
    S_WRITE = 3'b111,
    S_WAIT  = 3'b101
  } cslr_state_t;
  typedef struct packed {
    cslr_cls_t  cls;
    cslr_mode_t mode;
    cslr_sel_t  sel;
    logic [2:0] cyc;
    logic       bad;
  } cslr_dec_t;
  typedef struct packed {
    cslr_state_t state;
    cslr_dec_t   dec;
    logic [2:0]  cnt;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] ea;
    logic [7:0]  acc;
    logic [7:0]  ih;
    logic [7:0]  il;
    logic [7:0]  flg;
    logic [7:0]  tmp;
    logic        bad;
  } cslr_st_t;
  // ----------------------------------------
  // opcode decode
  // ----------------------------------------
  function automatic cslr_dec_t cslr_decode(input logic pg2, input logic [7:0] op);
    cslr_dec_t d;
    d = '{CL_IDLE, M_INH, R_ACC, CYC_ONE, 1'b1};
    if (pg2) begin
      case (op)
        OP_OR_IX2:  d = '{CL_OR, M_SP2, R_ACC, CYC_OR_SP2, 1'b0};
        OP_OR_IX1:  d = '{CL_OR, M_SP1, R_ACC, CYC_OR_SP1, 1'b0};
        OP_ROL_IX1: d = '{CL_ROL, M_SP1, R_ACC, CYC_ROL_SP1, 1'b0};
        default:    d.bad = 1'b1;
      endcase
    end else begin
      case (op)
        OP_IDLE:    d = '{CL_IDLE, M_INH, R_ACC, CYC_ONE, 1'b0};
        OP_NSWAP:   d = '{CL_NSWAP, M_INH, R_ACC, CYC_ONE, 1'b0};
        OP_OR_IMM:  d = '{CL_OR, M_IMM, R_ACC, CYC_OR_IMM, 1'b0};
        OP_OR_DIR:  d = '{CL_OR, M_DIR, R_ACC, CYC_OR_DIR, 1'b0};
        OP_OR_EXT:  d = '{CL_OR, M_EXT, R_ACC, CYC_OR_EXT, 1'b0};
        OP_OR_IX2:  d = '{CL_OR, M_IX2, R_ACC, CYC_OR_IX2, 1'b0};
        OP_OR_IX1:  d = '{CL_OR, M_IX1, R_ACC, CYC_OR_IX1, 1'b0};
        OP_OR_IX:   d = '{CL_OR, M_IX, R_ACC, CYC_OR_IX, 1'b0};
        OP_PSH_A:   d = '{CL_PUSH, M_INH, R_ACC, CYC_PUSH, 1'b0};
        OP_PSH_H:   d = '{CL_PUSH, M_INH, R_IH, CYC_PUSH, 1'b0};
        OP_PSH_X:   d = '{CL_PUSH, M_INH, R_IL, CYC_PUSH, 1'b0};
        OP_POP_A:   d = '{CL_POP, M_INH, R_ACC, CYC_POP, 1'b0};
        OP_POP_H:   d = '{CL_POP, M_INH, R_IH, CYC_POP, 1'b0};
        OP_POP_X:   d = '{CL_POP, M_INH, R_IL, CYC_POP, 1'b0};
        OP_ROL_DIR: d = '{CL_ROL, M_DIR, R_ACC, CYC_ROL_DIR, 1'b0};
        OP_ROL_A:   d = '{CL_ROL, M_INH, R_ACC, CYC_ONE, 1'b0};
        OP_ROL_X:   d = '{CL_ROL, M_INH, R_IL, CYC_ONE, 1'b0};
        OP_ROL_IX1: d = '{CL_ROL, M_IX1, R_ACC, CYC_ROL_IX1, 1'b0};
        OP_ROL_IX:  d = '{CL_ROL, M_IX, R_ACC, CYC_ROL_IX, 1'b0};
        default:    d.bad = 1'b1;
      endcase
    end
    return d;
  endfunction : cslr_decode
endpackage : cslr_pkg
`default_nettype wire

/* cslr_alu_if.sv */
// carrier between the executor and its logic unit
`timescale 1ns/100ps
`default_nettype none
interface cslr_alu_if;
  logic       rot;
  logic [7:0] opa;
  logic [7:0] opm;
  logic [7:0] flg_in;
  logic [7:0] res;
  logic [7:0] flg_out;
  modport core (output rot, output opa, output opm, output flg_in, input res, input flg_out);
  modport alu  (input rot, input opa, input opm, input flg_in, output res, output flg_out);
endinterface : cslr_alu_if
`default_nettype wire

/* cslr_alu.sv */
// or and rotate-left-through-carry unit with flag update
`timescale 1ns/100ps
`default_nettype none
module cslr_alu
  import cslr_pkg::*;
(
  cslr_alu_if.alu a
);
  always_comb begin
    a.flg_out = a.flg_in;
    if (a.rot) begin
      a.res            = {a.opa[6:0], a.flg_in[FLG_C]};
      a.flg_out[FLG_C] = a.opa[7];
      a.flg_out[FLG_V] = a.res[7] ^ a.opa[7];
    end else begin
      a.res            = a.opa | a.opm;
      a.flg_out[FLG_V] = 1'b0;
    end
    a.flg_out[FLG_N] = a.res[7];
    a.flg_out[FLG_Z] = (a.res == 8'h00);
  end
endmodule : cslr_alu
`default_nettype wire

/* cslr_exec.sv */
// instruction executor for idle, nibble swap, or, push, pop and rotate left
`timescale 1ns/100ps
`default_nettype none
module cslr_exec
  import cslr_pkg::*;
#(
  parameter logic [15:0] RST_PC = 16'h0000
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic      [15:0] mem_addr_o,
  output logic             mem_rd_o,
  output logic             mem_wr_o,
  output logic      [7:0]  mem_wdata_o,
  output logic             opcode_fetch_o,
  output logic             illegal_o,
  output logic      [15:0] pc_o,
  output logic      [15:0] stack_pointer_o,
  output logic      [7:0]  acc_o,
  output logic      [7:0]  index_high_o,
  output logic      [7:0]  index_low_o,
  output logic      [7:0]  flags_register_o
);
  // ----------------------------------------
  // state and helpers
  // ----------------------------------------
  cslr_st_t   st_ff;
  cslr_st_t   nxt_st;
  cslr_dec_t  dnow;
  logic       opc_here;
  logic [15:0] ea_full;
  logic [15:0] hx;
  logic       rd;
  logic       wr;
  cslr_alu_if alu_c ();

  cslr_alu u_alu (
    .a (alu_c)
  );

  localparam cslr_st_t ST_RST = '{
    state: S_FETCH,
    dec:   '{CL_IDLE, M_INH, R_ACC, CYC_ONE, 1'b0},
    cnt:   3'h0,
    pc:    RST_PC,
    sp:    SP_RST,
    ea:    16'h0000,
    acc:   8'h00,
    ih:    8'h00,
    il:    8'h00,
    flg:   FLG_RST,
    tmp:   8'h00,
    bad:   1'b0
  };

  // pads to the table count, back to fetch on the last cycle
  function automatic cslr_state_t step_end(input logic [2:0] cnt, input logic [2:0] cyc);
    return (cnt >= cyc - 3'h1) ? S_FETCH : S_WAIT;
  endfunction : step_end

  function automatic logic [15:0] ea_of(input cslr_mode_t m, input logic [15:0] off,
                                        input logic [15:0] hxv, input logic [15:0] spv);
    case (m)
      M_IX2, M_IX1: return hxv + off;
      M_IX:         return hxv;
      M_SP2, M_SP1: return spv + off;
      default:      return off;
    endcase
  endfunction : ea_of

  function automatic logic [7:0] pick(input cslr_sel_t s, input logic [7:0] av,
                                      input logic [7:0] hv, input logic [7:0] lv);
    case (s)
      R_IH:    return hv;
      R_IL:    return lv;
      default: return av;
    endcase
  endfunction : pick

  // ----------------------------------------
  // decode and data path
  // ----------------------------------------
  always_comb begin
    hx       = {st_ff.ih, st_ff.il};
    opc_here = ((st_ff.state == S_FETCH) && (mem_rdata_i != OP_PAGE2)) || (st_ff.state == S_PAGE2);
    if (st_ff.state == S_FETCH) begin
      dnow = cslr_decode(1'b0, mem_rdata_i);
    end else if (st_ff.state == S_PAGE2) begin
      dnow = cslr_decode(1'b1, mem_rdata_i);
    end else begin
      dnow = st_ff.dec;
    end
    ea_full      = ea_of(st_ff.dec.mode, st_ff.ea, hx, st_ff.sp);
    alu_c.rot    = (dnow.cls == CL_ROL);
    alu_c.flg_in = st_ff.flg;
    alu_c.opm    = mem_rdata_i;
    if (alu_c.rot && (dnow.mode == M_INH)) begin
      alu_c.opa = (dnow.sel == R_IL) ? st_ff.il : st_ff.acc;
    end else if (alu_c.rot) begin
      alu_c.opa = mem_rdata_i;
    end else begin
      alu_c.opa = st_ff.acc;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.cnt  = st_ff.cnt + 3'h1;
    nxt_st.bad  = 1'b0;
    mem_addr_o  = st_ff.pc;
    mem_wdata_o = 8'h00;
    rd          = 1'b0;
    wr          = 1'b0;
    case (st_ff.state)
      S_FETCH, S_PAGE2: begin
        rd        = 1'b1;
        nxt_st.pc = st_ff.pc + PC_STEP;
        if (!opc_here) begin
          nxt_st.state = S_PAGE2;
        end
      end
      S_OPND1: begin
        rd        = 1'b1;
        nxt_st.pc = st_ff.pc + PC_STEP;
        nxt_st.ea = {8'h00, mem_rdata_i};
        case (st_ff.dec.mode)
          M_EXT, M_IX2, M_SP2: nxt_st.state = S_OPND2;
          M_IMM: begin
            nxt_st.acc   = alu_c.res;
            nxt_st.flg   = alu_c.flg_out;
            nxt_st.state = step_end(st_ff.cnt, st_ff.dec.cyc);
          end
          default: nxt_st.state = S_READ;
        endcase
      end
      S_OPND2: begin
        rd           = 1'b1;
        nxt_st.pc    = st_ff.pc + PC_STEP;
        nxt_st.ea    = {st_ff.ea[7:0], mem_rdata_i};
        nxt_st.state = S_READ;
      end
      S_READ: begin
        rd         = 1'b1;
        mem_addr_o = (st_ff.dec.cls == CL_POP) ? st_ff.sp : ea_full;
        case (st_ff.dec.cls)
          CL_POP: begin
            case (st_ff.dec.sel)
              R_IH:    nxt_st.ih = mem_rdata_i;
              R_IL:    nxt_st.il = mem_rdata_i;
              default: nxt_st.acc = mem_rdata_i;
            endcase
            nxt_st.state = step_end(st_ff.cnt, st_ff.dec.cyc);
          end
          CL_ROL: begin
            nxt_st.tmp   = alu_c.res;
            nxt_st.flg   = alu_c.flg_out;
            nxt_st.state = S_WRITE;
          end
          default: begin
            nxt_st.acc   = alu_c.res;
            nxt_st.flg   = alu_c.flg_out;
            nxt_st.state = step_end(st_ff.cnt, st_ff.dec.cyc);
          end
        endcase
      end
      S_WRITE: begin
        wr = 1'b1;
        if (st_ff.dec.cls == CL_PUSH) begin
          mem_addr_o  = st_ff.sp;
          mem_wdata_o = pick(st_ff.dec.sel, st_ff.acc, st_ff.ih, st_ff.il);
          nxt_st.sp   = st_ff.sp - STK_STEP;
        end else begin
          mem_addr_o  = ea_full;
          mem_wdata_o = st_ff.tmp;
        end
        nxt_st.state = step_end(st_ff.cnt, st_ff.dec.cyc);
      end
      S_WAIT: begin
        nxt_st.state = step_end(st_ff.cnt, st_ff.dec.cyc);
      end
      default: begin
        nxt_st.state = S_FETCH;
      end
    endcase
    if (opc_here) begin
      nxt_st.dec = dnow;
      nxt_st.bad = dnow.bad;
      case (dnow.cls)
        CL_NSWAP: begin
          nxt_st.acc   = {st_ff.acc[3:0], st_ff.acc[7:4]};
          nxt_st.state = step_end(st_ff.cnt, dnow.cyc);
        end
        CL_PUSH: nxt_st.state = S_WRITE;
        CL_POP: begin
          nxt_st.sp    = st_ff.sp + STK_STEP;
          nxt_st.state = S_READ;
        end
        CL_OR, CL_ROL: begin
          if (dnow.mode == M_INH) begin
            if (dnow.sel == R_IL) begin
              nxt_st.il = alu_c.res;
            end else begin
              nxt_st.acc = alu_c.res;
            end
            nxt_st.flg   = alu_c.flg_out;
            nxt_st.state = step_end(st_ff.cnt, dnow.cyc);
          end else if (dnow.mode == M_IX) begin
            nxt_st.state = S_READ;
          end else begin
            nxt_st.state = S_OPND1;
          end
        end
        default: nxt_st.state = step_end(st_ff.cnt, dnow.cyc);
      endcase
    end
    if (nxt_st.state == S_FETCH) begin
      nxt_st.cnt = 3'h0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= ST_RST;
    end else if (ce_i) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign mem_rd_o         = rd & ce_i;
  assign mem_wr_o         = wr & ce_i;
  assign opcode_fetch_o   = (st_ff.state == S_FETCH) & ce_i;
  assign illegal_o        = st_ff.bad;
  assign pc_o             = st_ff.pc;
  assign stack_pointer_o  = st_ff.sp;
  assign acc_o            = st_ff.acc;
  assign index_high_o     = st_ff.ih;
  assign index_low_o      = st_ff.il;
  assign flags_register_o = st_ff.flg;
endmodule : cslr_exec
`default_nettype wire

/* cslr_mem_model.sv */
// behavioural program, data and stack memory on the executor bus
`timescale 1ns/100ps
`default_nettype none
module cslr_mem_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] mem_addr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_wr_i,
  input  wire logic [7:0]  mem_wdata_i,
  output logic      [7:0]  mem_rdata_o
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end
  // released bus shows the inverted byte, never a held value
  assign mem_rdata_o = mem_rd_i ? mem[mem_addr_i] : ~mem[mem_addr_i];
  always @(posedge clk_i) begin
    if (mem_wr_i) begin
      mem[mem_addr_i] <= mem_wdata_i;
    end
  end
endmodule : cslr_mem_model
`default_nettype wire

/* cslr_exec_sva.sv */
// assertion checker for the stack, logic and rotate executor
`timescale 1ns/100ps
`default_nettype none
module cslr_exec_sva
  import cslr_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic [15:0] mem_addr_o,
  input wire logic        mem_rd_o,
  input wire logic        mem_wr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic        opcode_fetch_o,
  input wire logic [15:0] pc_o,
  input wire logic [15:0] stack_pointer_o,
  input wire logic [7:0]  acc_o,
  input wire logic [7:0]  index_high_o,
  input wire logic [7:0]  index_low_o,
  input wire logic [7:0]  flags_register_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_fetch(logic [7:0] op);
    opcode_fetch_o && mem_rdata_i == op;
  endsequence
  sequence s_push;
    s_fetch(OP_PSH_A) or s_fetch(OP_PSH_H) or s_fetch(OP_PSH_X);
  endsequence
  sequence s_pop;
    s_fetch(OP_POP_A) or s_fetch(OP_POP_H) or s_fetch(OP_POP_X);
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  idle_step_a: assert property (
    s_fetch(OP_IDLE) ##1 ce_i |-> opcode_fetch_o && pc_o == $past(pc_o) + 16'h0001
      && $stable(acc_o) && $stable(flags_register_o) && $stable(stack_pointer_o))
    else $error("idle step changed state or length");
  nibble_swap_a: assert property (
    s_fetch(OP_NSWAP) |=> {acc_o[3:0], acc_o[7:4]} == $past(acc_o) && $stable(flags_register_o))
    else $error("nibble swap wrong");
  or_imm_a: assert property (
    s_fetch(OP_OR_IMM) ##1 ce_i ##1 ce_i |-> opcode_fetch_o && acc_o == ($past(acc_o) | $past(mem_rdata_i)))
    else $error("or immediate result or length wrong");
  or_flags_a: assert property (
    s_fetch(OP_OR_IMM) ##1 ce_i |=> !flags_register_o[FLG_V] && flags_register_o[FLG_N] == acc_o[7]
      && flags_register_o[FLG_Z] == (acc_o == 8'h00) && $stable(flags_register_o[FLG_C])
      && $stable(flags_register_o[FLG_H]) && $stable(flags_register_o[FLG_I]))
    else $error("or flags wrong");
  push_step_a: assert property (
    s_push ##1 ce_i |-> mem_wr_o && mem_addr_o == stack_pointer_o
      ##1 stack_pointer_o == $past(stack_pointer_o) - 16'h0001)
    else $error("push address or stack step wrong");
  push_data_a: assert property (
    s_fetch(OP_PSH_A) ##1 ce_i |-> mem_wdata_o == acc_o && $stable(flags_register_o))
    else $error("push data wrong");
  pop_step_a: assert property (
    s_pop ##1 ce_i |-> mem_rd_o && mem_addr_o == stack_pointer_o
      && stack_pointer_o == $past(stack_pointer_o) + 16'h0001)
    else $error("pop read address wrong");
  pop_acc_a: assert property (
    s_fetch(OP_POP_A) ##1 ce_i |=> acc_o == $past(mem_rdata_i) && $stable(flags_register_o))
    else $error("pop data wrong");
  rol_acc_a: assert property (
    s_fetch(OP_ROL_A) |=> {flags_register_o[FLG_C], acc_o} == {$past(acc_o), $past(flags_register_o[FLG_C])})
    else $error("rotate accumulator wrong");
  rol_flags_a: assert property (
    s_fetch(OP_ROL_A) |=> flags_register_o[FLG_N] == acc_o[7] && flags_register_o[FLG_Z] == (acc_o == 8'h00)
      && flags_register_o[FLG_V] == (flags_register_o[FLG_N] ^ flags_register_o[FLG_C])
      && $stable(flags_register_o[FLG_H]) && $stable(flags_register_o[FLG_I]))
    else $error("rotate flags wrong");
  rol_write_a: assert property (
    s_fetch(OP_ROL_IX) ##1 ce_i ##1 ce_i |-> mem_wr_o && mem_addr_o == {index_high_o, index_low_o}
      && {flags_register_o[FLG_C], mem_wdata_o} == {$past(mem_rdata_i), $past(flags_register_o[FLG_C])})
    else $error("rotate write back wrong");
  rol_len_a: assert property (
    s_fetch(OP_ROL_IX) ##1 ce_i[*4] |-> opcode_fetch_o)
    else $error("rotate indexed length wrong");
  rol_sp_len_a: assert property (
    s_fetch(OP_PAGE2) ##1 (ce_i && mem_rdata_i == OP_ROL_IX1) ##1 ce_i[*5] |-> opcode_fetch_o)
    else $error("rotate stack offset length wrong");
endmodule : cslr_exec_sva
bind cslr_exec cslr_exec_sva i_cslr_exec_sva (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .opcode_fetch_o(opcode_fetch_o),
  .pc_o(pc_o), .stack_pointer_o(stack_pointer_o), .acc_o(acc_o), .index_high_o(index_high_o),
  .index_low_o(index_low_o), .flags_register_o(flags_register_o));
`default_nettype wire

/* cslr_exec_tb_top.sv */
// self-checking bench running a program through the executor
`timescale 1ns/100ps
`default_nettype none
module cslr_exec_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        ce_i = 1'b1;
  logic [7:0]  mem_rdata;
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic        fetch;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [7:0]  acc;
  logic [7:0]  ih;
  logic [7:0]  il;
  logic [7:0]  flg;
  logic        ill;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc_cnt   = 0;
  logic [7:0]  prog [0:42] = '{8'h9d, 8'haa, 8'h81, 8'h49, 8'h62, 8'h87, 8'h88, 8'h8b, 8'h89, 8'h8a, 8'h59,
    8'h39, 8'h80, 8'hba, 8'h80, 8'hca, 8'h01, 8'h00, 8'hda, 8'h00, 8'h10, 8'hea, 8'h02, 8'hfa, 8'h9e, 8'hda,
    8'h00, 8'h03, 8'h9e, 8'hea, 8'h04, 8'h69, 8'h05, 8'h79, 8'h9e, 8'h69, 8'h06, 8'h86, 8'h39, 8'h90, 8'h39,
    8'h91, 8'h9d};
  logic [23:0] dat [0:10] = '{24'h0080_80, 24'h0090_c1, 24'h0091_01, 24'h0100_84, 24'h0101_10, 24'h0102_40,
    24'h0104_c0, 24'h2041_08, 24'h2043_02, 24'h2046_7f, 24'h2051_01};
  logic [23:0] memchk [0:7] = '{24'h00ff_00, 24'h00fe_20, 24'h0080_00, 24'h2046_ff, 24'h2041_10,
    24'h0104_80, 24'h0090_83, 24'h0091_03};
  // length, cycles, stack low, acc, index high, index low, flags
  logic [55:0] steps [0:24] = '{
    56'h01_01_ff_00_00_00_68, 56'h02_02_ff_81_00_00_6c, 56'h01_01_ff_02_00_00_e9, 56'h01_01_ff_20_00_00_e9,
    56'h01_02_fe_20_00_00_e9, 56'h01_03_ff_20_00_20_e9, 56'h01_02_fe_20_00_20_e9, 56'h01_02_fd_20_00_20_e9,
    56'h01_03_fe_20_20_20_e9, 56'h01_01_fe_20_20_41_68, 56'h02_05_fe_20_20_41_eb, 56'h02_03_fe_20_20_41_69,
    56'h03_04_fe_a4_20_41_6d, 56'h03_04_fe_a5_20_41_6d, 56'h02_03_fe_a7_20_41_6d, 56'h01_03_fe_af_20_41_6d,
    56'h04_05_fe_bf_20_41_6d, 56'h03_04_fe_ff_20_41_6d, 56'h02_05_fe_ff_20_41_ec, 56'h01_04_fe_ff_20_41_68,
    56'h03_06_fe_ff_20_41_6d, 56'h01_03_ff_00_20_41_6d, 56'h02_05_ff_00_20_41_6d, 56'h02_05_ff_00_20_41_68,
    56'h01_01_ff_00_20_41_68};
  // ----------------------------------------
  // design and memory
  // ----------------------------------------
  cslr_exec #(.RST_PC(16'h0000)) i_cslr_exec (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .mem_rdata_i(mem_rdata), .mem_addr_o(mem_addr),
    .mem_rd_o(mem_rd), .mem_wr_o(mem_wr), .mem_wdata_o(mem_wdata), .opcode_fetch_o(fetch), .illegal_o(ill),
    .pc_o(pc), .stack_pointer_o(sp), .acc_o(acc), .index_high_o(ih), .index_low_o(il), .flags_register_o(flg));
  cslr_mem_model i_cslr_mem_model (
    .clk_i(clk_i), .mem_addr_i(mem_addr), .mem_rd_i(mem_rd), .mem_wr_i(mem_wr), .mem_wdata_i(mem_wdata),
    .mem_rdata_o(mem_rdata));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16
  task automatic run_instr(output logic [7:0] n);
    int g;
    n = 8'h00;
    g = 0;
    do begin
      if (ce_i) n = n + 8'h01;
      @(posedge clk_i);
      #1;
      g++;
    end while (fetch !== 1'b1 && g < 50);
  endtask : run_instr
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------
  // clock, stalls and timeout
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    ce_i    <= !((cyc_cnt >= 30 && cyc_cnt <= 32) || cyc_cnt == 56);
    if (cyc_cnt == 1000) begin
      err_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0]  n;
    logic [15:0] pc_exp;
    logic [55:0] e;
    rst_i = 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 43; i++) i_cslr_mem_model.mem[i] = prog[i];
    for (int k = 0; k < 11; k++) i_cslr_mem_model.mem[dat[k][23:8]] = dat[k][7:0];
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    cmp16(pc, 16'h0000);
    cmp16(sp, 16'h00ff);
    cmp8(flg, 8'h68);
    cmp8({7'h00, ill}, 8'h00);
    pc_exp = 16'h0000;
    for (int k = 0; k < 25; k++) begin
      e = steps[k];
      run_instr(n);
      pc_exp = pc_exp + {8'h00, e[55:48]};
      cmp8(n, e[47:40]);
      cmp16(pc, pc_exp);
      cmp16(sp, {8'h00, e[39:32]});
      cmp8(acc, e[31:24]);
      cmp8(ih, e[23:16]);
      cmp8(il, e[15:8]);
      cmp8(flg, e[7:0]);
      cmp8({7'h00, ill}, 8'h00);
    end
    $display("test instruction sequence done");
    run_instr(n);
    cmp8(n, 8'h01);
    cmp16(pc, 16'h002c);
    cmp8({7'h00, ill}, 8'h01);
    cmp8(flg, 8'h68);
    $display("test unknown opcode done");
    for (int k = 0; k < 8; k++) begin
      cmp8(i_cslr_mem_model.mem[memchk[k][23:8]], memchk[k][7:0]);
    end
    $display("test memory image done");
    conclude();
  end
endmodule : cslr_exec_tb_top
`default_nettype wire
